// [rtl/fault_status_bytes.sv]
// Bank of four fault status bytes reached by command code with Read Byte and Write Byte.
// Assumes the PMBus engine outside decodes transactions into strobes synchronous to clk.
// Assumes the alert mask register and the summary byte assembly sit outside this bank.
`timescale 1ns/1ns
`default_nettype none
module fault_status_bytes (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Command access from the bus engine.
  input wire logic [7:0] cmd_code,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_wdata,
  input wire logic clear_faults,
  output logic [7:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_hit,
  // Fault events from the detectors.
  input wire logic overcurrent_fault_flag,
  input wire logic overcurrent_warn_flag,
  input wire logic undercurrent_fault_flag,
  input wire logic input_overvoltage_fault_flag,
  input wire logic input_overvoltage_warn_flag,
  input wire logic input_undervoltage_warn_flag,
  input wire logic overtemp_fault_flag,
  input wire logic overtemp_warn_flag,
  input wire logic bad_command_flag,
  input wire logic bad_data_flag,
  input wire logic pec_fail_event,
  input wire logic memory_error_event,
  input wire logic logic_core_error_flag,
  input wire logic other_error_flag_a,
  input wire logic back_channel_fault,
  input wire logic loop_follower,
  // Live supply levels.
  input wire logic power_input_rail_above_on,
  input wire logic power_input_rail_below_off,
  input wire logic internal_5v_supply_uvlo,
  // Alert masks, one bit per byte position.
  input wire logic [7:0] iout_alert_mask,
  input wire logic [7:0] input_alert_mask,
  input wire logic [7:0] temp_alert_mask,
  input wire logic [7:0] cml_alert_mask,
  // Status summaries and alert request.
  output logic iout_summary,
  output logic input_summary,
  output logic temp_summary,
  output logic cml_summary,
  output logic alert_request
);
  import fault_status_pkg::*;

  // Registered state of the bank outside the sticky bytes; every output is one of these fields.
  typedef struct packed {
    logic input_off;
    logic seen_turn_on;
    logic [7:0] rdata;
    logic rvalid;
    logic hit;
    logic iout_sum;
    logic input_sum;
    logic temp_sum;
    logic cml_sum;
    logic alert;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Per-byte set and write-one-to-clear vectors.
  logic [7:0] iout_set;
  logic [7:0] input_set;
  logic [7:0] temp_set;
  logic [7:0] cml_set;
  logic [7:0] iout_w1c;
  logic [7:0] input_w1c;
  logic [7:0] temp_w1c;
  logic [7:0] cml_w1c;
  // Latched flags as the sticky bytes hold them.
  logic [7:0] iout_flags;
  logic [7:0] input_flags;
  logic [7:0] temp_flags;
  logic [7:0] cml_flags;
  // Input byte as read, and the flags allowed to raise the alert.
  logic [7:0] input_byte;
  logic [7:0] input_alert_src;
  // Alert share of each byte after masking.
  logic [3:0] byte_alert;
  // Decoded command code and the merged other-other_error_flag_a source.
  logic code_known;
  logic other_error_flag_a_fault;

  // A follower folds back-channel faults into its own other-other_error_flag_a flag.
  // A leader leaves the back-channel input out, since that fault is not its own.
  assign other_error_flag_a_fault = other_error_flag_a | (loop_follower & back_channel_fault);

  // True for the four codes that this bank answers; any other code is refused.
  assign code_known = (cmd_code == CMD_IOUT_STATUS) || (cmd_code == CMD_INPUT_STATUS) ||
                      (cmd_code == CMD_TEMP_STATUS) || (cmd_code == CMD_CML_STATUS);

  // Set vectors place each detector at its flag's bit position.
  // A detector that stays high keeps its flag set through a clear, since the set wins in that cycle.
  always_comb begin
    // The current byte keeps three supported flags.
    iout_set = 8'h00;
    iout_set[OC_FAULT_BIT] = overcurrent_fault_flag;
    iout_set[OC_WARN_BIT] = overcurrent_warn_flag;
    iout_set[UC_FAULT_BIT] = undercurrent_fault_flag;
    input_set = 8'h00;
    input_set[INPUT_OVERVOLTAGE_FAULT_FLAG_BIT] = input_overvoltage_fault_flag;
    input_set[INPUT_OVERVOLTAGE_WARN_FLAG_BIT] = input_overvoltage_warn_flag;
    input_set[INPUT_UNDERVOLTAGE_WARN_FLAG_BIT] = input_undervoltage_warn_flag;
    temp_set = 8'h00;
    temp_set[OT_FAULT_BIT] = overtemp_fault_flag;
    temp_set[OT_WARN_BIT] = overtemp_warn_flag;
    // A follower's back-channel fault shares the other-other_error_flag_a bit.
    cml_set = 8'h00;
    cml_set[BAD_CMD_BIT] = bad_command_flag;
    cml_set[BAD_DATA_BIT] = bad_data_flag;
    cml_set[PEC_BIT] = pec_fail_event;
    cml_set[MEM_BIT] = memory_error_event;
    cml_set[CORE_BIT] = logic_core_error_flag;
    cml_set[OTHER_OTHER_ERROR_FLAG_A_BIT] = other_error_flag_a_fault;
  end

  // Write Byte to a code turns its data into a write-one-to-clear vector.
  // Unknown codes leave every vector at zero, so stray writes change nothing.
  always_comb begin
    iout_w1c = 8'h00;
    input_w1c = 8'h00;
    temp_w1c = 8'h00;
    cml_w1c = 8'h00;
    if (cmd_write && cmd_code == CMD_IOUT_STATUS) begin
      iout_w1c = cmd_wdata;
    end else if (cmd_write && cmd_code == CMD_INPUT_STATUS) begin
      input_w1c = cmd_wdata;
    end else if (cmd_write && cmd_code == CMD_TEMP_STATUS) begin
      temp_w1c = cmd_wdata;
    end else if (cmd_write && cmd_code == CMD_CML_STATUS) begin
      cml_w1c = cmd_wdata;
    end
  end

  // Sticky bytes; the supported masks force read-only bits to zero.
  // A set and a clear in one cycle leave the flag set, so no event is lost.
  sticky_flag_byte #(.SUPPORTED(IOUT_SUPPORTED)) iout_byte_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(iout_set),
    .w1c_in(iout_w1c),
    .clear_all(clear_faults),
    .flags(iout_flags)
  );

  sticky_flag_byte #(.SUPPORTED(INPUT_LATCHED)) input_byte_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(input_set),
    .w1c_in(input_w1c),
    .clear_all(clear_faults),
    .flags(input_flags)
  );

  sticky_flag_byte #(.SUPPORTED(TEMP_SUPPORTED)) temp_byte_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(temp_set),
    .w1c_in(temp_w1c),
    .clear_all(clear_faults),
    .flags(temp_flags)
  );

  sticky_flag_byte #(.SUPPORTED(CML_SUPPORTED)) cml_byte_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .set_in(cml_set),
    .w1c_in(cml_w1c),
    .clear_all(clear_faults),
    .flags(cml_flags)
  );

  // The input byte carries the live off indicator beside its latched flags.
  // The live bit is not latched, so writes and clears never reach it.
  always_comb begin
    input_byte = input_flags;
    input_byte[INPUT_OFF_BIT] = state_reg.input_off;
  end

  // Alert sources of the input byte exclude the live bit and gate undervoltage warn.
  // Without the gate, an input still ramping up at power-on would raise an alert.
  always_comb begin
    input_alert_src = input_flags;
    input_alert_src[INPUT_OFF_BIT] = 1'b0;
    if (!state_reg.seen_turn_on) begin
      input_alert_src[INPUT_UNDERVOLTAGE_WARN_FLAG_BIT] = 1'b0;
    end
  end

  // Each byte raises its share of the alert only through unmasked flags.
  always_comb begin
    byte_alert[0] = |(iout_flags & ~iout_alert_mask);
    byte_alert[1] = |(input_alert_src & ~input_alert_mask);
    byte_alert[2] = |(temp_flags & ~temp_alert_mask);
    byte_alert[3] = |(cml_flags & ~cml_alert_mask);
  end

  // Next state: live indicator, turn-on memory, read port, summaries, alert.
  always_comb begin
    state_next = state_reg;
    // Hysteresis between turn-on and turn-off thresholds; low 5V inhibits at once.
    if (internal_5v_supply_uvlo || power_input_rail_below_off) begin
      state_next.input_off = 1'b1;
    end else if (power_input_rail_above_on) begin
      state_next.input_off = 1'b0;
    end
    // Remember the first turn-on since reset; it opens the undervoltage alert.
    if (power_input_rail_above_on) begin
      state_next.seen_turn_on = 1'b1;
    end
    // Reads latch their byte, so cmd_rdata holds until the next read.
    state_next.rvalid = cmd_read;
    state_next.hit = 1'b0;
    // Unknown codes read zero and leave hit low.
    if (cmd_read) begin
      state_next.rdata = 8'h00;
      if (cmd_code == CMD_IOUT_STATUS) begin
        state_next.rdata = iout_flags;
        state_next.hit = 1'b1;
      end else if (cmd_code == CMD_INPUT_STATUS) begin
        state_next.rdata = input_byte;
        state_next.hit = 1'b1;
      end else if (cmd_code == CMD_TEMP_STATUS) begin
        state_next.rdata = temp_flags;
        state_next.hit = 1'b1;
      end else if (cmd_code == CMD_CML_STATUS) begin
        state_next.rdata = cml_flags;
        state_next.hit = 1'b1;
      end
    end else if (cmd_write) begin
      state_next.hit = code_known;
    end
    // Summaries and the alert trail the flags by one cycle.
    state_next.iout_sum = |iout_flags;
    state_next.input_sum = |input_flags;
    state_next.temp_sum = |temp_flags;
    state_next.cml_sum = |cml_flags;
    state_next.alert = |byte_alert;
  end

  // State register; the live off indicator starts set.
  // Reset is synchronous, so it takes hold at the next clk edge only.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '{
        input_off: INPUT_OFF_RESET,
        seen_turn_on: 1'b0,
        rdata: FLAGS_RESET,
        rvalid: 1'b0,
        hit: 1'b0,
        iout_sum: 1'b0,
        input_sum: 1'b0,
        temp_sum: 1'b0,
        cml_sum: 1'b0,
        alert: 1'b0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state register.
  assign cmd_rdata = state_reg.rdata;
  assign cmd_rvalid = state_reg.rvalid;
  assign cmd_hit = state_reg.hit;
  assign iout_summary = state_reg.iout_sum;
  assign input_summary = state_reg.input_sum;
  assign temp_summary = state_reg.temp_sum;
  assign cml_summary = state_reg.cml_sum;
  assign alert_request = state_reg.alert;
endmodule : fault_status_bytes
`default_nettype wire

// [rtl/fault_status_pkg.sv]
// Package for the fault status byte bank: command codes, bit positions, reset values.
// Assumes a command decoder outside that presents one Read Byte or Write Byte at a time.
package fault_status_pkg;
  localparam logic [7:0] CMD_IOUT_STATUS = 8'h7b;
  localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
  localparam logic [7:0] CMD_TEMP_STATUS = 8'h7d;
  localparam logic [7:0] CMD_CML_STATUS = 8'h7e;
  // Supported bit masks of each byte.
  localparam logic [7:0] IOUT_SUPPORTED = 8'hb0;
  localparam logic [7:0] INPUT_LATCHED = 8'he0;
  localparam logic [7:0] TEMP_SUPPORTED = 8'hc0;
  localparam logic [7:0] CML_SUPPORTED = 8'hfa;
  // Bit positions.
  localparam int OC_FAULT_BIT = 7;
  localparam int OC_WARN_BIT = 5;
  localparam int UC_FAULT_BIT = 4;
  localparam int INPUT_OVERVOLTAGE_FAULT_FLAG_BIT = 7;
  localparam int INPUT_OVERVOLTAGE_WARN_FLAG_BIT = 6;
  localparam int INPUT_UNDERVOLTAGE_WARN_FLAG_BIT = 5;
  localparam int INPUT_OFF_BIT = 3;
  localparam int OT_FAULT_BIT = 7;
  localparam int OT_WARN_BIT = 6;
  localparam int BAD_CMD_BIT = 7;
  localparam int BAD_DATA_BIT = 6;
  localparam int PEC_BIT = 5;
  localparam int MEM_BIT = 4;
  localparam int CORE_BIT = 3;
  localparam int OTHER_OTHER_ERROR_FLAG_A_BIT = 1;
  // Reset values.
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic INPUT_OFF_RESET = 1'b1;
endpackage : fault_status_pkg

// [rtl/sticky_flag_byte.sv]
// One byte of sticky flags with write-one-to-clear and a global clear.
// Assumes set inputs are one-cycle or level conditions from the fault detectors.
`timescale 1ns/1ns
`default_nettype none
module sticky_flag_byte #(
  parameter logic [7:0] SUPPORTED = 8'hff
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Flag control.
  input wire logic [7:0] set_in,
  input wire logic [7:0] w1c_in,
  input wire logic clear_all,
  // Flag state.
  output logic [7:0] flags
);
  import fault_status_pkg::*;

  typedef struct packed {
    logic [7:0] flags;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Clears drop flags, then sets win; unsupported bits are forced to zero.
  always_comb begin
    state_next = state_reg;
    state_next.flags = state_reg.flags & ~w1c_in;
    if (clear_all) begin
      state_next.flags = FLAGS_RESET;
    end
    state_next.flags = (state_next.flags | set_in) & SUPPORTED;
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '{flags: FLAGS_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags = state_reg.flags;
endmodule : sticky_flag_byte
`default_nettype wire

// [tb/fault_status_assertions.sv]
// Checker for the fault status byte bank, bound onto its top ports.
// Assumes sys_rst is the synchronous reset of the single clk domain.
`timescale 1ns/1ns
`default_nettype none
module fault_status_assertions (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Command side.
  input wire logic [7:0] cmd_code,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic cmd_hit,
  // Events, masks and summaries.
  input wire logic overcurrent_fault_flag,
  input wire logic bad_command_flag,
  input wire logic [7:0] iout_alert_mask,
  input wire logic [7:0] input_alert_mask,
  input wire logic [7:0] temp_alert_mask,
  input wire logic [7:0] cml_alert_mask,
  input wire logic iout_summary,
  input wire logic cml_summary,
  input wire logic alert_request
);
  import fault_status_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A read of one given code.
  sequence s_rd(c);
    cmd_read && cmd_code == c;
  endsequence
  // Every alert masked for two cycles running.
  sequence s_masked;
    ((iout_alert_mask & input_alert_mask & temp_alert_mask & cml_alert_mask) == 8'hff) [*2];
  endsequence
  // A write alone to one of the four codes, or to any other code.
  sequence s_wr_known;
    cmd_write && !cmd_read && cmd_code inside {[8'h7b:8'h7e]};
  endsequence
  sequence s_wr_unknown;
    cmd_write && !cmd_read && !(cmd_code inside {[8'h7b:8'h7e]});
  endsequence
  AST_RVALID: assert property (cmd_read |=> cmd_rvalid)
    else $error("read not answered");
  AST_HIT: assert property (cmd_read && cmd_code inside {[8'h7b:8'h7e]} |=> cmd_hit)
    else $error("known code not hit");
  AST_UNKNOWN: assert property (cmd_read && !(cmd_code inside {[8'h7b:8'h7e]})
    |=> cmd_rdata == 8'h00 && !cmd_hit) else $error("unknown code answered");
  AST_IOUT_RO: assert property (s_rd(8'h7b) |=> (cmd_rdata & ~IOUT_SUPPORTED) == 8'h00)
    else $error("current byte reserved bits set");
  AST_TEMP_RO: assert property (s_rd(8'h7d) |=> (cmd_rdata & ~TEMP_SUPPORTED) == 8'h00)
    else $error("temperature byte reserved bits set");
  AST_CML_RO: assert property (s_rd(8'h7e) |=> (cmd_rdata & ~CML_SUPPORTED) == 8'h00)
    else $error("other_error_flag_a byte reserved bits set");
  AST_OC_SUM: assert property (overcurrent_fault_flag |-> ##2 iout_summary)
    else $error("current summary late");
  AST_CML_SUM: assert property (bad_command_flag |-> ##2 cml_summary)
    else $error("other_error_flag_a summary late");
  AST_MASK: assert property (s_masked |-> !alert_request)
    else $error("masked alert raised");
  AST_WR_HIT: assert property (s_wr_known |=> cmd_hit)
    else $error("known code write not hit");
  AST_WR_MISS: assert property (s_wr_unknown |=> !cmd_hit)
    else $error("unknown code write hit");
  AST_INPUT_RO: assert property (s_rd(8'h7c) |=>
    (cmd_rdata & ~(INPUT_LATCHED | (8'h01 << INPUT_OFF_BIT))) == 8'h00)
    else $error("input byte reserved bits set");
endmodule : fault_status_assertions

bind fault_status_bytes fault_status_assertions fault_status_assertions_i (
  .clk(clk),
  .sys_rst(sys_rst),
  .cmd_code(cmd_code),
  .cmd_read(cmd_read),
  .cmd_write(cmd_write),
  .cmd_rdata(cmd_rdata),
  .cmd_rvalid(cmd_rvalid),
  .cmd_hit(cmd_hit),
  .overcurrent_fault_flag(overcurrent_fault_flag),
  .bad_command_flag(bad_command_flag),
  .iout_alert_mask(iout_alert_mask),
  .input_alert_mask(input_alert_mask),
  .temp_alert_mask(temp_alert_mask),
  .cml_alert_mask(cml_alert_mask),
  .iout_summary(iout_summary),
  .cml_summary(cml_summary),
  .alert_request(alert_request)
);
`default_nettype wire

// [tb/fault_status_bytes_bench.sv]
// Self-checking bench for the fault status byte bank driven by a host model.
// Assumes the package, design, host model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module fault_status_bytes_bench;
  import fault_status_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [14:0] ev = '0;
  logic above_on = 1'b0;
  logic below_off = 1'b0;
  logic uvlo = 1'b0;
  logic follower = 1'b1;
  logic [7:0] mask = 8'h00;
  logic [7:0] code, wdata, rdata, d, w;
  logic rd_s, wr_s, clr, rvalid, hit, alert, v;
  logic [3:0] sums;
  int n_mismatch = 0;
  int comparisons = 0;
  localparam logic [7:0] CODE [15] = '{8'h7b, 8'h7b, 8'h7b, 8'h7c, 8'h7c, 8'h7c, 8'h7d,
    8'h7d, 8'h7e, 8'h7e, 8'h7e, 8'h7e, 8'h7e, 8'h7e, 8'h7e};
  localparam logic [7:0] BITS [15] = '{8'h80, 8'h20, 8'h10, 8'h80, 8'h40, 8'h20, 8'h80,
    8'h40, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h02};
  fault_status_bytes fault_status_bytes_i (.clk(clk), .sys_rst(sys_rst), .cmd_code(code),
    .cmd_read(rd_s), .cmd_write(wr_s), .cmd_wdata(wdata), .clear_faults(clr),
    .cmd_rdata(rdata), .cmd_rvalid(rvalid), .cmd_hit(hit), .overcurrent_fault_flag(ev[0]),
    .overcurrent_warn_flag(ev[1]), .undercurrent_fault_flag(ev[2]),
    .input_overvoltage_fault_flag(ev[3]), .input_overvoltage_warn_flag(ev[4]),
    .input_undervoltage_warn_flag(ev[5]), .overtemp_fault_flag(ev[6]),
    .overtemp_warn_flag(ev[7]), .bad_command_flag(ev[8]), .bad_data_flag(ev[9]),
    .pec_fail_event(ev[10]), .memory_error_event(ev[11]), .logic_core_error_flag(ev[12]),
    .other_error_flag_a(ev[13]), .back_channel_fault(ev[14]), .loop_follower(follower),
    .power_input_rail_above_on(above_on), .power_input_rail_below_off(below_off),
    .internal_5v_supply_uvlo(uvlo), .iout_alert_mask(mask), .input_alert_mask(mask),
    .temp_alert_mask(mask), .cml_alert_mask(mask), .iout_summary(sums[0]),
    .input_summary(sums[1]), .temp_summary(sums[2]), .cml_summary(sums[3]),
    .alert_request(alert));
  status_host_model status_host_model_i (.clk(clk), .cmd_code(code), .cmd_read(rd_s),
    .cmd_write(wr_s), .cmd_wdata(wdata), .clear_faults(clr), .cmd_rdata(rdata),
    .cmd_rvalid(rvalid));
  // Free-running clock.
  always #5 clk = ~clk;
  // Expected byte after a write-one-to-clear.
  function automatic logic [7:0] w1c(input logic [7:0] f, input logic [7:0] x);
    return f & ~x;
  endfunction : w1c
  // Compares one value with its expectation.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Reads one code and checks the answer strobe and data.
  task automatic rc(input logic [7:0] c, input logic [7:0] e);
    status_host_model_i.rd(c, d, v);
    chk({7'h0, v}, 8'h01);
    chk(d, e);
  endtask : rc
  // One-cycle detector event.
  task automatic pulse(input int i);
    @(negedge clk);
    ev[i] = 1'b1;
    @(negedge clk);
    ev[i] = 1'b0;
  endtask : pulse
  // Prints the verdict and ends the run.
  task automatic final_report();
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // Cuts a hang short.
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h4ecfbb84));
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    rc(8'h7b, FLAGS_RESET);
    chk({7'h0, hit}, 8'h01);
    rc(8'h7c, 8'h08);
    rc(8'h7d, FLAGS_RESET);
    chk({7'h0, alert}, 8'h00);
    pulse(5);
    rc(8'h7c, 8'h28);
    chk({7'h0, alert}, 8'h00);
    above_on = 1'b1;
    rc(8'h7c, 8'h20);
    chk({7'h0, alert}, 8'h01);
    status_host_model_i.wr(8'h00, 8'h00, 1'b1);
    rc(8'h7c, 8'h00);
    for (int i = 0; i < 15; i++) begin
      pulse(i);
      rc(CODE[i], BITS[i]);
      chk({7'h0, sums[2'(CODE[i][1:0] + 2'd1)]}, 8'h01);
      chk({7'h0, alert}, 8'h01);
      w = 8'($urandom) & ~BITS[i];
      status_host_model_i.wr(CODE[i], w, 1'b0);
      rc(CODE[i], w1c(BITS[i], w));
      status_host_model_i.wr(CODE[i], w | BITS[i], 1'b0);
      rc(CODE[i], w1c(BITS[i], w | BITS[i]));
      chk({7'h0, sums[2'(CODE[i][1:0] + 2'd1)]}, 8'h00);
    end
    ev[9] = 1'b1;
    status_host_model_i.wr(8'h7e, 8'h40, 1'b0);
    rc(8'h7e, 8'h40);
    status_host_model_i.wr(8'h00, 8'h00, 1'b1);
    rc(8'h7e, 8'h40);
    ev[9] = 1'b0;
    status_host_model_i.wr(8'h7e, 8'h40, 1'b0);
    rc(8'h7e, 8'h00);
    mask = 8'hff;
    pulse(0);
    rc(8'h7b, 8'h80);
    chk({7'h0, alert}, 8'h00);
    mask = 8'h00;
    status_host_model_i.wr(8'h7b, 8'h4f, 1'b0);
    rc(8'h7b, 8'h80);
    chk({7'h0, alert}, 8'h01);
    status_host_model_i.wr(8'h00, 8'h00, 1'b1);
    uvlo = 1'b1;
    rc(8'h7b, 8'h00);
    rc(8'h7c, 8'h08);
    {uvlo, above_on, below_off} = 3'b001;
    rc(8'h7c, 8'h08);
    chk({7'h0, alert}, 8'h00);
    chk({7'h0, sums[1]}, 8'h00);
    {below_off, above_on} = 2'b01;
    rc(8'h7c, 8'h00);
    follower = 1'b0;
    pulse(14);
    rc(8'h7e, 8'h00);
    follower = 1'b1;
    above_on = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rc(8'h7c, 8'h08);
    pulse(5);
    rc(8'h7c, 8'h28);
    chk({7'h0, alert}, 8'h00);
    status_host_model_i.wr(8'h7f, 8'hff, 1'b0);
    rc(8'h7c, 8'h28);
    status_host_model_i.gap = 2;
    rc(8'h7f, 8'h00);
    chk({7'h0, hit}, 8'h00);
    rc(8'h80 | 8'($urandom), 8'h00);
    final_report();
  end
endmodule : fault_status_bytes_bench
`default_nettype wire

// [tb/status_host_model.sv]
// Host model issuing Read Byte, Write Byte and clear-faults requests.
// Assumes the bank takes each request on the rising clk edge.
`timescale 1ns/1ns
`default_nettype none
module status_host_model (
  // Clock.
  input wire logic clk,
  // Requests.
  output logic [7:0] cmd_code,
  output logic cmd_read,
  output logic cmd_write,
  output logic [7:0] cmd_wdata,
  output logic clear_faults,
  // Answers.
  input wire logic [7:0] cmd_rdata,
  input wire logic cmd_rvalid
);
  int gap = 0;
  // Idle bus from time zero.
  initial begin
    {cmd_code, cmd_read, cmd_write, cmd_wdata, clear_faults} = '0;
  end
  // Read Byte; released lines show the inverse so stale values never match.
  task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic v);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    cmd_code = c;
    cmd_read = 1'b1;
    @(negedge clk);
    cmd_read = 1'b0;
    cmd_code = ~c;
    d = cmd_rdata;
    v = cmd_rvalid;
  endtask : rd
  // Write Byte of write-one-to-clear data, or a clear-faults pulse.
  task automatic wr(input logic [7:0] c, input logic [7:0] w, input logic clr);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    cmd_code = c;
    cmd_wdata = w;
    cmd_write = !clr;
    clear_faults = clr;
    @(negedge clk);
    {cmd_write, clear_faults} = 2'b00;
    cmd_code = ~c;
    cmd_wdata = ~w;
  endtask : wr
endmodule : status_host_model
`default_nettype wire
